// File: design/bgpio_top.sv
// top: axi4-lite register slave with two gpio port slices
// =====================================================
`timescale 1ns/100ps
module bgpio_top
  import bgpio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleepClamp,
  input wire logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] clampExempt,
  input wire logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padIn,
  output logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padOut,
  output logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padOe,
  output logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padPullup
);
  bgpio_strobe_if strb[BGPIO_PORTS] ();

  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic [1:0] mcu_control_reg;
  logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] altOwned_reg;
  logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] exemptSync1_reg;
  logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] exemptSync2_reg;
  logic sleepSync1_reg;
  logic sleepSync2_reg;
  logic [BGPIO_PORTS-1:0] portHit;
  bgpio_sel_t wrSel;
  logic wrMapped;
  logic [31:0] rdWord;
  logic rdMapped;
  logic [BGPIO_WIDTH-1:0] portVal [BGPIO_PORTS];
  logic [BGPIO_WIDTH-1:0] portDir [BGPIO_PORTS];
  logic [BGPIO_WIDTH-1:0] portPin [BGPIO_PORTS];

  // address to port number and selector, shared by read and write decode
  function automatic bgpio_sel_t selOf(input logic [7:0] addr);
    case (addr)
      BGPIO_OFF_PIN0, BGPIO_OFF_PIN1: selOf = BGPIO_SEL_PIN;
      BGPIO_OFF_DIR0, BGPIO_OFF_DIR1: selOf = BGPIO_SEL_DIR;
      BGPIO_OFF_VAL0, BGPIO_OFF_VAL1: selOf = BGPIO_SEL_VAL;
      default: selOf = BGPIO_SEL_NONE;
    endcase
  endfunction

  function automatic logic portOf(input logic [7:0] addr);
    portOf = (addr >= BGPIO_OFF_PIN1) ? 1'b1 : 1'b0;
  endfunction

  // =====================================================
  // pad input synchronizers for the shared sleep and exemption levels
  // data pins get their own latch plus register inside each slice
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sleepSync1_reg <= 1'b0;
      sleepSync2_reg <= 1'b0;
      exemptSync1_reg <= '0;
      exemptSync2_reg <= '0;
    end else begin
      sleepSync1_reg <= sleepClamp;
      sleepSync2_reg <= sleepSync1_reg;
      exemptSync1_reg <= clampExempt;
      exemptSync2_reg <= exemptSync1_reg;
    end
  end

  // =====================================================
  // axi write channel: address and data taken in either order
  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;
  assign doWrite = awHeld_reg & wHeld_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end
  end

  always_comb begin
    wrSel = selOf(awAddr_reg);
    wrMapped = (wrSel != BGPIO_SEL_NONE) || (awAddr_reg == BGPIO_OFF_CTRL)
      || (awAddr_reg == BGPIO_OFF_ALT);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BGPIO_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? BGPIO_RESP_OKAY : BGPIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // =====================================================
  // per-port strobes; only byte lane 0 carries port data
  always_comb begin
    for (int p = 0; p < BGPIO_PORTS; p++) begin
      portHit[p] = doWrite && wStrb_reg[0] && (portOf(awAddr_reg) == p[0]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < BGPIO_PORTS; g++) begin : gPort
      assign strb[g].writeValueStrobe = portHit[g] && (wrSel == BGPIO_SEL_VAL);
      assign strb[g].writeDirectionStrobe = portHit[g] && (wrSel == BGPIO_SEL_DIR);
      assign strb[g].writePinStrobe = portHit[g] && (wrSel == BGPIO_SEL_PIN);
      assign strb[g].writeData = wData_reg[BGPIO_WIDTH-1:0];
      assign portVal[g] = strb[g].outputValue;
      assign portDir[g] = strb[g].direction;
      assign portPin[g] = strb[g].pinInput;

      bgpio_port u_port (
        .clock(clock),
        .sys_rst(sys_rst),
        .globalPullupOff(mcu_control_reg[BGPIO_CTRL_PUOFF_BIT]),
        .sleepClamp(sleepSync2_reg | mcu_control_reg[BGPIO_CTRL_SLEEP_BIT]),
        .altOwned(altOwned_reg[g*BGPIO_WIDTH +: BGPIO_WIDTH]),
        .clampExempt(exemptSync2_reg[g*BGPIO_WIDTH +: BGPIO_WIDTH]),
        .padIn(padIn[g*BGPIO_WIDTH +: BGPIO_WIDTH]),
        .padOut(padOut[g*BGPIO_WIDTH +: BGPIO_WIDTH]),
        .padOe(padOe[g*BGPIO_WIDTH +: BGPIO_WIDTH]),
        .padPullup(padPullup[g*BGPIO_WIDTH +: BGPIO_WIDTH]),
        .strb(strb[g].port)
      );
    end
  endgenerate

  // =====================================================
  // shared control: pull-up disable, software sleep, alternate ownership
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mcu_control_reg <= BGPIO_CTRL_RST;
    end else if (doWrite && wStrb_reg[0] && awAddr_reg == BGPIO_OFF_CTRL) begin
      mcu_control_reg <= wData_reg[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      altOwned_reg <= '0;
    end else if (doWrite && awAddr_reg == BGPIO_OFF_ALT) begin
      if (wStrb_reg[0]) begin
        altOwned_reg[7:0] <= wData_reg[7:0];
      end
      if (wStrb_reg[1]) begin
        altOwned_reg[15:8] <= wData_reg[15:8];
      end
    end
  end

  // =====================================================
  // axi read channel: one read at a time, data from a register
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    rdWord = 32'h00000000;
    rdMapped = 1'b1;
    case (selOf(s_axi_araddr))
      BGPIO_SEL_PIN: rdWord[7:0] = portPin[portOf(s_axi_araddr)];
      BGPIO_SEL_DIR: rdWord[7:0] = portDir[portOf(s_axi_araddr)];
      BGPIO_SEL_VAL: rdWord[7:0] = portVal[portOf(s_axi_araddr)];
      default: begin
        if (s_axi_araddr == BGPIO_OFF_CTRL) begin
          rdWord[1:0] = mcu_control_reg;
        end else if (s_axi_araddr == BGPIO_OFF_ALT) begin
          rdWord[15:0] = altOwned_reg;
        end else begin
          rdMapped = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= BGPIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdMapped ? BGPIO_RESP_OKAY : BGPIO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: shared/bgpio_pkg.sv
// package: register map, field layout and reset values of the gpio port block
package bgpio_pkg;
  localparam int BGPIO_WIDTH = 8;
  localparam int BGPIO_PORTS = 2;
  localparam int BGPIO_WORD_COUNT = 8;
  // byte addresses, 32-bit aligned words
  localparam logic [7:0] BGPIO_OFF_PIN0 = 8'h00;
  localparam logic [7:0] BGPIO_OFF_DIR0 = 8'h04;
  localparam logic [7:0] BGPIO_OFF_VAL0 = 8'h08;
  localparam logic [7:0] BGPIO_OFF_PIN1 = 8'h0C;
  localparam logic [7:0] BGPIO_OFF_DIR1 = 8'h10;
  localparam logic [7:0] BGPIO_OFF_VAL1 = 8'h14;
  localparam logic [7:0] BGPIO_OFF_CTRL = 8'h18;
  localparam logic [7:0] BGPIO_OFF_ALT = 8'h1C;
  localparam int BGPIO_CTRL_PUOFF_BIT = 0;
  localparam int BGPIO_CTRL_SLEEP_BIT = 1;
  localparam logic [7:0] BGPIO_DIR_RST = 8'h00;
  localparam logic [7:0] BGPIO_VAL_RST = 8'h00;
  localparam logic [1:0] BGPIO_CTRL_RST = 2'h0;
  localparam logic [1:0] BGPIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] BGPIO_RESP_SLVERR = 2'h2;
  // register selector within a port: pin, direction, value
  typedef enum logic [1:0] {
    BGPIO_SEL_PIN = 2'h0,
    BGPIO_SEL_DIR = 2'h1,
    BGPIO_SEL_VAL = 2'h2,
    BGPIO_SEL_NONE = 2'h3
  } bgpio_sel_t;
endpackage

// File: shared/bgpio_strobe_if.sv
// interface: per-port register strobes between the bus slave and a port slice
`timescale 1ns/100ps
interface bgpio_strobe_if;
  logic writeValueStrobe;
  logic writeDirectionStrobe;
  logic writePinStrobe;
  logic [7:0] writeData;
  logic [7:0] outputValue;
  logic [7:0] direction;
  logic [7:0] pinInput;
  modport ctrl (output writeValueStrobe, output writeDirectionStrobe, output writePinStrobe,
    output writeData, input outputValue, input direction, input pinInput);
  modport port (input writeValueStrobe, input writeDirectionStrobe, input writePinStrobe,
    input writeData, output outputValue, output direction, output pinInput);
endinterface

// File: design/bgpio_sync.sv
// two-stage pin input synchronizer: high-transparent latch plus rising-edge register
`timescale 1ns/100ps
module bgpio_sync
  import bgpio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [BGPIO_WIDTH-1:0] padIn,
  output logic [BGPIO_WIDTH-1:0] syncOut
);
  logic [BGPIO_WIDTH-1:0] latchStage;

  // =====================================================
  // latch open while clock high, holds while low
  always_latch begin
    if (clock) begin
      latchStage = padIn;
    end
  end

  // =====================================================
  // second stage: only reader of the latch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      syncOut <= '0;
    end else begin
      syncOut <= latchStage;
    end
  end
endmodule

// File: design/bgpio_port.sv
// one gpio port slice: direction, output value, toggle, pad control and pin readback
`timescale 1ns/100ps
module bgpio_port
  import bgpio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic globalPullupOff,
  input wire logic sleepClamp,
  input wire logic [BGPIO_WIDTH-1:0] altOwned,
  input wire logic [BGPIO_WIDTH-1:0] clampExempt,
  input wire logic [BGPIO_WIDTH-1:0] padIn,
  output logic [BGPIO_WIDTH-1:0] padOut,
  output logic [BGPIO_WIDTH-1:0] padOe,
  output logic [BGPIO_WIDTH-1:0] padPullup,
  bgpio_strobe_if.port strb
);
  logic [BGPIO_WIDTH-1:0] output_value_reg;
  logic [BGPIO_WIDTH-1:0] direction_reg;
  logic [BGPIO_WIDTH-1:0] clampedIn;
  logic [BGPIO_WIDTH-1:0] pin_input_reg;

  // =====================================================
  // registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      direction_reg <= BGPIO_DIR_RST;
    end else if (strb.writeDirectionStrobe) begin
      direction_reg <= strb.writeData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      output_value_reg <= BGPIO_VAL_RST;
    end else if (strb.writeValueStrobe) begin
      output_value_reg <= strb.writeData;
    end else if (strb.writePinStrobe) begin
      // ones invert, zeros keep; direction plays no part
      output_value_reg <= output_value_reg ^ strb.writeData;
    end
  end

  // =====================================================
  // pad control; reset gates the enables without the clock
  always_comb begin
    padOut = output_value_reg;
    padOe = sys_rst ? '0 : direction_reg;
    // alt-owned pins get no pull-up but still follow direction and value, the rest unaffected
    padPullup = sys_rst ? '0 : (~direction_reg & output_value_reg & ~altOwned
      & {BGPIO_WIDTH{~globalPullupOff}});
    clampedIn = padIn & ~({BGPIO_WIDTH{sleepClamp}} & ~clampExempt);
  end

  bgpio_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .padIn(clampedIn),
    .syncOut(pin_input_reg)
  );

  assign strb.outputValue = output_value_reg;
  assign strb.direction = direction_reg;
  assign strb.pinInput = pin_input_reg;
endmodule

// File: verif/bgpio_pins.sv
// partner: pin-level model of the circuitry outside the port pins
`timescale 1ns/100ps
module bgpio_pins (
  input wire logic clock,
  input wire logic [15:0] padOut,
  input wire logic [15:0] padOe,
  input wire logic [15:0] padPullup,
  input wire logic [15:0] extVal,
  input wire logic [15:0] extEn,
  output logic [15:0] padIn
);
  // ====
  // pin resolution
  logic [15:0] floatVal = 16'h0;
  // an undriven pin wanders, so a stale level never passes for a real one
  always @(posedge clock) floatVal <= ~floatVal;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extEn[i]) padIn[i] = extVal[i];
      else if (padPullup[i]) padIn[i] = 1'h1;
      else padIn[i] = floatVal[i];
    end
  end
endmodule

// File: verif/bgpio_top_asserts.sv
// checker: port-level properties of the gpio block
`timescale 1ns/100ps
module bgpio_top_asserts
  import bgpio_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padOut,
  input wire logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padOe,
  input wire logic [BGPIO_PORTS*BGPIO_WIDTH-1:0] padPullup
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ====
  // bus steps
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ====
  // properties
  a_reset_clear: assert property ($fell(sys_rst) |-> padOe == '0 && padOut == '0)
    else $error("pads not idle after reset");
  a_no_pull_out: assert property ((padPullup & padOe) == '0)
    else $error("pull-up on a driven pin");
  a_pull_needs_one: assert property ((padPullup & ~padOut) == '0)
    else $error("pull-up with value bit zero");
  a_pad_on_write: assert property ($changed({padOut, padOe, padPullup}) |-> $rose(s_axi_bvalid))
    else $error("pad control moved without a write");
  a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule
bind bgpio_top bgpio_top_asserts i_bgpio_top_asserts (.*);

// File: verif/bgpio_top_tb.sv
// testbench: register-level checks of the gpio block
`timescale 1ns/100ps
module bgpio_top_tb;
  import bgpio_pkg::*;
  logic clock = 1'h0, sys_rst = 1'h1, sleepClamp = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, b;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // pin 4 of each port is left open, so only the pull-up can hold it high
  logic [15:0] clampExempt = 16'h00FF, extVal = 16'h5050, extEn = 16'hEFEF, padIn, padOut, padOe, padPullup;
  int error_cnt = 0, comparisons = 0;
  bgpio_top i_bgpio_top (.*);
  bgpio_pins i_bgpio_pins (.clock(clock), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .extVal(extVal), .extEn(extEn), .padIn(padIn));
  initial begin
    forever #20 clock = ~clock;
  end
  // ====
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    $display("MISMATCH t=%0t no bus answer", $time);
    give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ok = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        ok = 1;
        s_axi_bready <= 1'h0;
        check(s_axi_bresp, er);
      end
    end
    if (!ok) hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ok = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        ok = 1;
        s_axi_rready <= 1'h0;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
      end
    end
    if (!ok) hang();
  endtask
  // ====
  // main sequence
  initial begin
    repeat (3) @(negedge clock);
    check(padOe, 16'h0);
    check(padPullup, 16'h0);
    repeat (9) @(posedge clock);
    sys_rst <= 1'h0;
    for (int p = 0; p < 2; p++) begin
      b = p ? BGPIO_OFF_PIN1 : BGPIO_OFF_PIN0;
      rd(b + 8'h04, 32'h0, BGPIO_RESP_OKAY);
      rd(b + 8'h08, 32'h0, BGPIO_RESP_OKAY);
      wr(b + 8'h08, 32'hA5, BGPIO_RESP_OKAY);
      check(padPullup[p*8 +: 8], 8'hA5);
      wr(b + 8'h04, 32'h0F, BGPIO_RESP_OKAY);
      check(padOe[p*8 +: 8], 8'h0F);
      check(padOut[p*8 +: 4], 4'h5);
      check(padPullup[p*8 +: 8], 8'hA0);
      wr(b, 32'h3C, BGPIO_RESP_OKAY);
      rd(b, 32'h59, BGPIO_RESP_OKAY);
      rd(b + 8'h08, 32'h99, BGPIO_RESP_OKAY);
      rd(b + 8'h04, 32'h0F, BGPIO_RESP_OKAY);
    end
    wr(BGPIO_OFF_CTRL, 32'h1, BGPIO_RESP_OKAY);
    check(padPullup, 16'h0);
    wr(BGPIO_OFF_CTRL, 32'h0, BGPIO_RESP_OKAY);
    check(padPullup, 16'h9090);
    wr(BGPIO_OFF_ALT, 32'h0080, BGPIO_RESP_OKAY);
    check(padPullup, 16'h9010);
    check(padOe, 16'h0F0F);
    extVal <= 16'hA0A0;
    repeat (2) @(posedge clock);
    rd(BGPIO_OFF_PIN0, 32'hB9, BGPIO_RESP_OKAY);
    sleepClamp <= 1'h1;
    repeat (6) @(posedge clock);
    rd(BGPIO_OFF_PIN1, 32'h0, BGPIO_RESP_OKAY);
    rd(BGPIO_OFF_PIN0, 32'hB9, BGPIO_RESP_OKAY);
    sleepClamp <= 1'h0;
    repeat (6) @(posedge clock);
    rd(BGPIO_OFF_PIN1, 32'hB9, BGPIO_RESP_OKAY);
    // software sleep bit must clamp on its own
    wr(BGPIO_OFF_CTRL, 32'h2, BGPIO_RESP_OKAY);
    rd(BGPIO_OFF_PIN1, 32'h0, BGPIO_RESP_OKAY);
    rd(BGPIO_OFF_PIN0, 32'hB9, BGPIO_RESP_OKAY);
    rd(BGPIO_OFF_CTRL, 32'h2, BGPIO_RESP_OKAY);
    wr(BGPIO_OFF_CTRL, 32'h0, BGPIO_RESP_OKAY);
    rd(BGPIO_OFF_ALT, 32'h80, BGPIO_RESP_OKAY);
    // pull-up input to output low, stepping through output high
    wr(BGPIO_OFF_DIR1, 32'h8F, BGPIO_RESP_OKAY);
    check(padOe, 16'h8F0F);
    check(padPullup, 16'h1010);
    check(padOut, 16'h9999);
    wr(BGPIO_OFF_PIN1, 32'h80, BGPIO_RESP_OKAY);
    check(padOut, 16'h1999);
    check(padPullup, 16'h1010);
    check(padOe, 16'h8F0F);
    rd(8'h20, 32'h0, BGPIO_RESP_SLVERR);
    wr(8'h20, 32'h1, BGPIO_RESP_SLVERR);
    give_verdict();
  end
endmodule
